/* hw/otc_consts.svh */
// Offsets, field positions, reset values and timing constants of the oscillator trim block
`ifndef OTC_CONSTS_SVH
`define OTC_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define OTC_CTL_IDX 8'h0F
`define OTC_AGING_IDX 8'h19
`define OTC_STAT_IDX 8'h20
`define OTC_ADDR_W 10

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define OTC_RELOAD_BIT 5
`define OTC_FREQ_OFF 3'h7
`define OTC_MEAS_SEL_RST 2'h0
`define OTC_FREQ_SEL_RST 3'h0
`define OTC_AGING_RST 4'h8
`define OTC_AGING_ZERO 11'sh008

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OTC_OSC_HZ 32768
`define OTC_CLK_HZ 100000000
`define OTC_RELOAD_MS 100
`define OTC_MEAS_S_00 8'hF0
`define OTC_MEAS_S_01 8'h78
`define OTC_MEAS_S_10 8'h3C
`define OTC_MEAS_S_11 8'h1E
`define OTC_SLOW_BIT 4'hF

`endif

/* hw/otc_pkg.sv */
// Types shared by the oscillator trim and clock output block
package otc_pkg;

  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] temp_meas_period_sel;
    logic calib_reload_trigger;
    logic [1:0] unused;
    logic [2:0] out_freq_sel;
  } otc_ctl_t;

  typedef struct packed {
    logic [3:0] unused;
    logic [3:0] aging_trim_code;
  } otc_aging_t;

  // ----------------------------------------------------------------
  // Calibration reload sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OTC_IDLE = 2'h0,
    OTC_WAIT = 2'h1,
    OTC_APPLY = 2'h3
  } otc_state_t;

endpackage

/* hw/otc_trim_square_wave_out.sv */
// Oscillator trim, temperature measurement pacing and square-wave output with APB registers
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "otc_consts.svh"

module otc_trim_square_wave_out
  import otc_pkg::*;
#(
  parameter int CLK_HZ = `OTC_CLK_HZ,
  parameter int OSC_HZ = `OTC_OSC_HZ,
  parameter int RELOAD_CYCLES = `OTC_RELOAD_MS * (`OTC_CLK_HZ / 1000),
  parameter int AGING_STEP = 1
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] TEMP_COMP,
  input wire logic TEMP_VALID,
  input wire logic [7:0] OTP_DATA,
  output logic TEMP_MEAS_START,
  output logic CAL_RELOAD_REQ,
  output logic LOAD_CAP_SEL,
  output logic SQW_O,
  output logic SQW_OE_N
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CLK_HZ < 4 * OSC_HZ) begin : g_bad_clk
    $error("core clock too slow for oscillator rate");
  end
  if (RELOAD_CYCLES < 4) begin : g_bad_reload
    $error("reload time too short");
  end
  if (AGING_STEP < 1 || AGING_STEP > 8) begin : g_bad_step
    $error("aging step out of range");
  end

  localparam logic [32:0] ACC_INC = 33'(2 * OSC_HZ);
  localparam logic [32:0] ACC_TOP = 33'(CLK_HZ);
  localparam logic [31:0] RELOAD_LAST = 32'(RELOAD_CYCLES - 2);
  localparam logic signed [10:0] STEP = 11'(AGING_STEP);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Divider bit that carries a selected frequency
  function automatic logic [3:0] tap(input logic [2:0] sel);
    case (sel)
      3'h0: tap = 4'h0;
      3'h1: tap = 4'h1;
      3'h2: tap = 4'h2;
      3'h3: tap = 4'h3;
      3'h4: tap = 4'h4;
      3'h5: tap = 4'h5;
      3'h6: tap = `OTC_SLOW_BIT;
      default: tap = 4'h0;
    endcase
  endfunction

  // Seconds between temperature measurements
  function automatic logic [7:0] period_s(input logic [1:0] sel);
    case (sel)
      2'h0: period_s = `OTC_MEAS_S_00;
      2'h1: period_s = `OTC_MEAS_S_01;
      2'h2: period_s = `OTC_MEAS_S_10;
      default: period_s = `OTC_MEAS_S_11;
    endcase
  endfunction

  // True when all divider bits up to and including bit m are zero
  function automatic logic low_up_to(input logic [15:0] cnt, input logic [3:0] m);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (i <= int'(m) && cnt[i]) begin
        ok = 1'b0;
      end
    end
    low_up_to = ok;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  otc_ctl_t ctl_q, ctl_d;
  logic reload_bit_q, reload_bit_d;
  otc_aging_t aging_q, aging_d;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q, prdata_d;
  logic [32:0] acc_q, acc_d;
  logic [15:0] div_q, div_d;
  logic [2:0] cur_sel_q, cur_sel_d;
  logic wave_q, wave_d;
  logic sqw_o_q;
  logic first_q;
  logic [7:0] sec_q, sec_d;
  logic [1:0] per_q, per_d;
  logic meas_q, meas_d;
  logic [7:0] temp_q;
  otc_state_t state_q, state_d;
  logic [31:0] rl_cnt_q, rl_cnt_d;
  logic [7:0] cal_q;
  logic req_q;
  logic [7:0] pwm_q;
  logic cap_q, cap_d;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic setup = PSEL & ~PENABLE & ~pready_q;
  wire logic wr_done = PSEL & PENABLE & pready_q & PWRITE;
  wire logic [`OTC_ADDR_W-1:0] addr = PADDR[`OTC_ADDR_W-1:0];
  wire logic hit_ctl = addr == {`OTC_CTL_IDX, 2'b00};
  wire logic hit_aging = addr == {`OTC_AGING_IDX, 2'b00};
  wire logic hit_stat = addr == {`OTC_STAT_IDX, 2'b00};
  wire logic hit_any = hit_ctl | hit_aging | hit_stat;
  wire logic wr_ctl = wr_done & hit_ctl & ~pslverr_q;
  wire logic wr_aging = wr_done & hit_aging & ~pslverr_q;
  wire logic busy = state_q != OTC_IDLE;

  wire otc_ctl_t ctl_view = '{temp_meas_period_sel: ctl_q.temp_meas_period_sel,
                               calib_reload_trigger: reload_bit_q, unused: 2'h0,
                               out_freq_sel: ctl_q.out_freq_sel};
  wire otc_aging_t aging_view = '{unused: 4'h0, aging_trim_code: aging_q.aging_trim_code};
  wire logic [7:0] stat_view = {4'h0, cur_sel_q == `OTC_FREQ_OFF, ~wave_q, first_q, busy};
  assign prdata_d = hit_ctl ? {24'h0, ctl_view} :
                    hit_aging ? {24'h0, aging_view} :
                    hit_stat ? {24'h0, stat_view} : 32'h0;

  // Register write data
  wire otc_ctl_t wctl = PWDATA[7:0];
  wire otc_aging_t waging = PWDATA[7:0];
  assign ctl_d = wr_ctl ? '{temp_meas_period_sel: wctl.temp_meas_period_sel,
                            calib_reload_trigger: 1'b0, unused: 2'h0,
                            out_freq_sel: wctl.out_freq_sel} : ctl_q;
  assign reload_bit_d = wr_ctl ? wctl.calib_reload_trigger : reload_bit_q;
  assign aging_d = wr_aging ? '{unused: 4'h0, aging_trim_code: waging.aging_trim_code} : aging_q;

  // 0 to 1 write of reload bit
  wire logic reload_start = wr_ctl & wctl.calib_reload_trigger & (reload_bit_q == 1'b0);

  // APB answer: one wait-free access phase
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit_any;
      prdata_q <= (setup & ~PWRITE) ? prdata_d : 32'h0;
    end
  end

  // Control registers
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_q <= '{temp_meas_period_sel: `OTC_MEAS_SEL_RST, calib_reload_trigger: 1'b0,
                 unused: 2'h0, out_freq_sel: `OTC_FREQ_SEL_RST};
      // aging code reset to zero correction
      aging_q <= '{unused: 4'h0, aging_trim_code: `OTC_AGING_RST};
    end else begin
      ctl_q <= ctl_d;
      aging_q <= aging_d;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    reload_bit_q <= reload_bit_d;
  end

  // ----------------------------------------------------------------
  // Oscillator tick and divider chain
  // ----------------------------------------------------------------
  // Phase accumulator gives half-period ticks of the oscillator
  wire logic [32:0] acc_sum = acc_q + ACC_INC;
  wire logic half_tick = acc_sum >= ACC_TOP;
  assign acc_d = half_tick ? acc_sum - ACC_TOP : acc_sum;
  assign div_d = half_tick ? div_q + 16'h1 : div_q;
  wire logic sec_tick = half_tick & (div_q == 16'hFFFF);

  // switch only where old and new waves both start a low phase
  wire logic [3:0] tap_cur = cur_sel_q == `OTC_FREQ_OFF ? 4'h0 : tap(cur_sel_q);
  wire logic [3:0] tap_new = ctl_q.out_freq_sel == `OTC_FREQ_OFF ? 4'h0 : tap(ctl_q.out_freq_sel);
  wire logic [3:0] tap_max = tap_cur > tap_new ? tap_cur : tap_new;
  wire logic can_switch = half_tick & low_up_to(div_d, tap_max);
  assign cur_sel_d = can_switch ? ctl_q.out_freq_sel : cur_sel_q;

  // selected divider bit, or release for 111
  // tap k toggles once every 2^k half ticks
  assign wave_d = !half_tick ? wave_q :
                  cur_sel_d == `OTC_FREQ_OFF ? 1'b1 : div_d[tap(cur_sel_d)];

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_q <= 33'h0;
      div_q <= 16'h0;
      cur_sel_q <= `OTC_FREQ_SEL_RST;
      wave_q <= 1'b0;
      sqw_o_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      div_q <= div_d;
      cur_sel_q <= cur_sel_d;
      wave_q <= wave_d;
      sqw_o_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Temperature measurement pacing
  // ----------------------------------------------------------------
  // period from latched selector
  wire logic period_end = sec_tick & ((sec_q + 8'h1) >= period_s(per_q));
  // one measurement right after reset, then periodic
  assign meas_d = first_q | period_end;
  assign sec_d = (first_q | period_end) ? 8'h0 : sec_tick ? sec_q + 8'h1 : sec_q;
  // new period taken at interval end
  assign per_d = (first_q | period_end) ? ctl_q.temp_meas_period_sel : per_q;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      first_q <= 1'b1;
      sec_q <= 8'h0;
      per_q <= `OTC_MEAS_SEL_RST;
      meas_q <= 1'b0;
      temp_q <= 8'h0;
    end else begin
      first_q <= 1'b0;
      sec_q <= sec_d;
      per_q <= per_d;
      meas_q <= meas_d;
      temp_q <= TEMP_VALID ? TEMP_COMP : temp_q;
    end
  end

  // ----------------------------------------------------------------
  // Calibration reload sequencer
  // ----------------------------------------------------------------
  // fixed wait then apply, inside the reload limit
  always_comb begin
    state_d = state_q;
    rl_cnt_d = rl_cnt_q;
    case (state_q)
      OTC_IDLE: begin
        rl_cnt_d = 32'h0;
        if (reload_start) begin
          state_d = OTC_WAIT;
        end
      end
      OTC_WAIT: begin
        rl_cnt_d = rl_cnt_q + 32'h1;
        if (rl_cnt_q >= RELOAD_LAST) begin
          state_d = OTC_APPLY;
        end
      end
      OTC_APPLY: begin
        state_d = OTC_IDLE;
      end
      default: begin
        state_d = OTC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= OTC_IDLE;
      rl_cnt_q <= 32'h0;
      cal_q <= 8'h0;
      req_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rl_cnt_q <= rl_cnt_d;
      cal_q <= (state_q == OTC_APPLY) ? OTP_DATA : cal_q;
      req_q <= reload_start & (state_q == OTC_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Load capacitance modulation
  // ----------------------------------------------------------------
  // signed aging offset, 8 minus code, in steps
  wire logic signed [10:0] aging_adj = (`OTC_AGING_ZERO - $signed({7'h0, aging_q.aging_trim_code})) * STEP;
  wire logic signed [10:0] duty_sum = $signed({3'h0, temp_q}) + $signed({{3{cal_q[7]}}, cal_q}) + aging_adj;
  wire logic [7:0] duty = duty_sum < 0 ? 8'h0 : duty_sum > 11'sh0FF ? 8'hFF : duty_sum[7:0];
  // programmable duty selects the load capacitor
  assign cap_d = pwm_q < duty;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwm_q <= 8'h0;
      cap_q <= 1'b0;
    end else begin
      pwm_q <= pwm_q + 8'h1;
      cap_q <= cap_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign TEMP_MEAS_START = meas_q;
  assign CAL_RELOAD_REQ = req_q;
  assign LOAD_CAP_SEL = cap_q;
  assign SQW_O = sqw_o_q;
  // open drain: drive low only while wave low
  assign SQW_OE_N = wave_q;

endmodule
`default_nettype wire

/* tb/otc_assertions.sv */
// Port-level checks of the oscillator trim block
`timescale 1ns/1ps
`default_nettype none
module otc_checker (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TEMP_MEAS_START,
  input wire logic CAL_RELOAD_REQ,
  input wire logic SQW_O,
  input wire logic SQW_OE_N
);
  logic [1:0] cnt_q;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // ----------
  // Cycles since reset release
  // ----------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) cnt_q <= 2'h0;
    else if (cnt_q != 2'h3) cnt_q <= cnt_q + 2'h1;
  end
  chk_ready_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  chk_ready_once: assert property (PREADY |-> PSEL && PENABLE ##1 !PREADY)
    else $error("ready outside one access cycle");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside access");
  chk_rdata_upper: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_ctl_gap: assert property (PREADY && !PWRITE && PADDR[9:0] == 10'h03C |-> PRDATA[4:3] == 2'h0)
    else $error("unused control bits set");
  chk_first_meas: assert property (cnt_q == 2'h1 |-> TEMP_MEAS_START ##1 !TEMP_MEAS_START)
    else $error("no measurement after reset");
  chk_reload_once: assert property (CAL_RELOAD_REQ |=> !CAL_RELOAD_REQ [*8])
    else $error("reload restarted");
  chk_open_drain: assert property (SQW_O == 1'b0)
    else $error("pin driven high");
  // Main scenarios
  cover property (CAL_RELOAD_REQ);
  cover property (PSLVERR);
  cover property ($rose(SQW_OE_N));
endmodule
bind otc_trim_square_wave_out otc_checker u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .TEMP_MEAS_START(TEMP_MEAS_START), .CAL_RELOAD_REQ(CAL_RELOAD_REQ),
  .SQW_O(SQW_O), .SQW_OE_N(SQW_OE_N));
`default_nettype wire

/* tb/otc_sqw_partner.sv */
// Model of a circuit that samples the square-wave pin on the core clock and times its phases
`timescale 1ns/1ps
`default_nettype none
module otc_sqw_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic [15:0] hi_len,
  output logic [15:0] lo_len,
  output logic [15:0] min_len,
  output logic [15:0] edges
);
  logic prev_q;
  logic [15:0] run_q;
  // times phases of the faster clocks, up to 65535 cycles
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      run_q <= 16'h1;
      hi_len <= 16'h0;
      lo_len <= 16'h0;
      min_len <= 16'hFFFF;
      edges <= 16'h0;
    end else if (pin !== prev_q) begin
      if (prev_q) hi_len <= run_q;
      else lo_len <= run_q;
      // First phase after reset may be partial
      if (edges > 16'h1 && run_q < min_len) min_len <= run_q;
      edges <= edges + 16'h1;
      prev_q <= pin;
      run_q <= 16'h1;
    end else run_q <= run_q + 16'h1;
  end
endmodule
`default_nettype wire

/* tb/otc_trim_square_wave_out_tb.sv */
// Self-checking bench of the oscillator trim block
`timescale 1ns/1ps
`default_nettype none
`include "otc_consts.svh"
module otc_trim_square_wave_out_tb
  import otc_pkg::*;
;
  localparam int RLD = 16;
  localparam logic [11:0] A_CTL = {2'h0, `OTC_CTL_IDX, 2'h0};
  localparam logic [11:0] A_AGE = {2'h0, `OTC_AGING_IDX, 2'h0};
  localparam logic [11:0] A_STAT = {2'h0, `OTC_STAT_IDX, 2'h0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] temp = 8'h80;
  logic [7:0] otp = 8'h00;
  logic tvalid = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, tms, creq, lcap, sqo, sqoe_n, er;
  logic [15:0] hi, lo, mn, eg;
  wire logic pin;
  int mismatches = 0;
  int checks_done = 0;
  int reloads = 0;
  int h;
  // Written value and expected read-back
  logic [15:0] pair_tbl [4] = '{16'hFFE7, 16'h5840, 16'h9A82, 16'hC3C3};
  // ----------
  // Clock, pull-up and reload counter
  // ----------
  always #5 clk = ~clk;
  assign pin = sqoe_n ? 1'b1 : sqo;
  always @(posedge clk) if (creq === 1'b1) reloads++;
  otc_trim_square_wave_out #(.CLK_HZ(131072), .RELOAD_CYCLES(RLD)) dut (.CORE_CLK(clk), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TEMP_COMP(temp), .TEMP_VALID(tvalid), .OTP_DATA(otp),
    .TEMP_MEAS_START(tms), .CAL_RELOAD_REQ(creq), .LOAD_CAP_SEL(lcap), .SQW_O(sqo), .SQW_OE_N(sqoe_n));
  otc_sqw_partner u_part (.clk(clk), .rst_n(rst_n), .pin(pin), .hi_len(hi), .lo_len(lo),
    .min_len(mn), .edges(eg));
  // ----------
  // Tasks
  // ----------
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer, waits for ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    chk(n < 20, 1, "ready wait");
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task reload;
    apb(1'b1, A_CTL, 32'h0);
    apb(1'b1, A_CTL, 32'h20);
    repeat (RLD + 4) @(posedge clk);
  endtask
  // High cycles of the modulation in one counter lap
  task duty(input logic [7:0] exp);
    h = 0;
    repeat (8) @(posedge clk);
    repeat (256) begin
      @(posedge clk);
      if (lcap === 1'b1) h++;
    end
    chk(h, {24'h0, exp}, "duty");
  endtask
  // ----------
  // Tests
  // ----------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    tvalid <= 1'b1;
    @(posedge clk);
    tvalid <= 1'b0;
    apb(1'b0, A_CTL, 32'h0);
    chk(rd & 32'hDF, 32'h0, "ctl reset");
    apb(1'b0, A_AGE, 32'h0);
    chk(rd, 32'h08, "aging reset");
    reload();
    chk(reloads, 1, "reload start");
    apb(1'b1, A_CTL, 32'h20);
    repeat (RLD + 4) @(posedge clk);
    chk(reloads, 1, "no retrigger");
    $display("end reload");
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, A_AGE, {28'hFFFFFFF, 4'(i)});
      apb(1'b0, A_AGE, 32'h0);
      chk(rd, i, "aging read");
      duty(8'(136 - i));
    end
    apb(1'b1, A_AGE, 32'h8);
    otp <= 8'h04;
    reload();
    duty(8'h84);
    $display("end trim");
    foreach (pair_tbl[k]) begin
      apb(1'b1, A_CTL, {24'h0, pair_tbl[k][15:8]});
      apb(1'b0, A_CTL, 32'h0);
      chk(rd, {24'h0, pair_tbl[k][7:0]}, "ctl read");
    end
    chk(reloads, 2, "reload count");
    $display("end regs");
    for (int s = 0; s < 6; s++) begin
      apb(1'b1, A_CTL, s);
      repeat ((2 << s) * 8 + 64) @(posedge clk);
      chk({16'h0, hi}, 2 << s, "high time");
      chk({16'h0, lo}, 2 << s, "low time");
    end
    apb(1'b1, A_CTL, 32'h7);
    repeat (200) @(posedge clk);
    h = eg;
    repeat (200) @(posedge clk);
    chk({16'h0, eg}, h, "pin released");
    chk(mn >= 16'h2, 1, "no glitch");
    chk({16'h0, lo}, 32'h40, "clean release");
    apb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h08, "status off");
    apb(1'b0, 12'h100, 32'h0);
    chk({rd[30:0], er}, 32'h1, "unmapped");
    $display("end output");
    apb(1'b1, A_CTL, 32'hA5);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, A_CTL, 32'h0);
    chk(rd, 32'h20, "bit kept");
    repeat (64) @(posedge clk);
    chk({16'h0, hi}, 2, "active at reset");
    $display("end second reset");
    report_and_stop();
  end
  // Hang guard
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
